// File: src/pcl_loader.sv
// Purpose: Program counter register and its load control for the core.
// Assumes: Decoder gives at most one load strobe per fetch; all inputs are synchronous.
// Notes: Counter moves on fetch_en or pc_low_write; low-byte writes take effect at the next clock, even without a fetch.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Hold a 15-bit address counter; low byte readable and writable.
// - Upper seven bits change by latch copy, call operand bits or increment/branch carry.
// - Any reset clears the whole counter to zero.
// - Writing the low byte also loads upper bits from the high latch.
// - Direct call: operand gives low byte and bits 10:8; latch gives 14:11.
// - Accumulator call: low byte from accumulator, upper bits from latch.
// - Accumulator branch: incremented address plus unsigned accumulator.
// - Immediate branch: incremented address plus signed operand.
module pcl_loader (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic fetch_en,
    input wire logic pc_low_write,
    input wire logic [7:0] pc_low_write_data,
    input wire logic call_direct,
    input wire logic call_via_accumulator,
    input wire logic branch_rel_accumulator,
    input wire logic branch_rel_immediate,
    input wire logic [10:0] op_field,
    input wire logic [7:0] acc_value,
    input wire logic [6:0] pc_high_latch,
    output pcl_pkg::pcl_addr_t pc_addr,
    output logic [7:0] pc_low_byte_reg,
    output logic load_error
);
    import pcl_pkg::*;

    // Number of load strobes the decoder can raise
    localparam int PCL_N_STROBES = 5;

    // Strobe slots; a lower slot index has the higher priority
    localparam int PCL_SLOT_LOW = 0;
    localparam int PCL_SLOT_CALL = 1;
    localparam int PCL_SLOT_CALL_ACC = 2;
    localparam int PCL_SLOT_BR_ACC = 3;
    localparam int PCL_SLOT_BR_IMM = 4;

    // Whole counter as seen by the target logic
    pcl_addr_t pc_now;
    pcl_addr_t pc_next;
    pcl_addr_t pc_target;

    // Upper counter bits; software never reaches them directly
    logic [PCL_HIGH_W-1:0] pc_upper_bits_reg;
    logic [PCL_HIGH_W-1:0] pc_upper_bits_next;

    // Low byte; its flops also drive the low-byte output
    logic [PCL_LOW_W-1:0] low_byte_reg;
    logic [PCL_LOW_W-1:0] low_byte_next;

    // Load selection
    pcl_load_e load_kind;
    logic [PCL_N_STROBES-1:0] strobe_vec;
    logic [PCL_N_STROBES-1:0] higher_vec;
    logic [PCL_N_STROBES-1:0] win_vec;
    logic [2:0] strobe_count;
    logic any_jump;
    logic multi_load;
    logic load_taken;
    logic orphan_jump;

    // Fault flags, all sticky until reset
    logic multi_err_reg;
    logic multi_err_next;
    logic orphan_err_reg;
    logic orphan_err_next;
    logic err_reg;
    logic err_next;

    // Gather the strobes in priority order
    assign strobe_vec[PCL_SLOT_LOW] = pc_low_write;
    assign strobe_vec[PCL_SLOT_CALL] = call_direct;
    assign strobe_vec[PCL_SLOT_CALL_ACC] = call_via_accumulator;
    assign strobe_vec[PCL_SLOT_BR_ACC] = branch_rel_accumulator;
    assign strobe_vec[PCL_SLOT_BR_IMM] = branch_rel_immediate;

    // A slot is masked when any higher-priority slot is raised
    assign higher_vec[0] = 1'b0;
    for (genvar i = 1; i < PCL_N_STROBES; i++) begin : g_mask
        assign higher_vec[i] = higher_vec[i - 1] | strobe_vec[i - 1];
    end

    // At most one winner survives, even when the decoder misbehaves,
    // so the counter never loads a blend of two targets
    for (genvar i = 0; i < PCL_N_STROBES; i++) begin : g_win
        assign win_vec[i] = strobe_vec[i] & ~higher_vec[i];
    end

    // Count raised strobes to spot decoder faults
    always_comb begin
        strobe_count = 3'h0;
        for (int k = 0; k < PCL_N_STROBES; k++) begin
            strobe_count = strobe_count + {2'h0, strobe_vec[k]};
        end
    end

    assign multi_load = (strobe_count > 3'h1);
    assign any_jump = |strobe_vec[PCL_SLOT_BR_IMM:PCL_SLOT_CALL];
    assign load_taken = pc_low_write | fetch_en;

    // A jump strobe with no fetch to carry it is dropped and flagged;
    // acting on it would skip an instruction the decoder never issued
    assign orphan_jump = any_jump & ~load_taken;

    // Map the winning slot onto a load kind
    always_comb begin
        load_kind = PCL_LD_INC;
        if (win_vec[PCL_SLOT_LOW]) begin
            load_kind = PCL_LD_LOW_WRITE;
        end else if (win_vec[PCL_SLOT_CALL]) begin
            load_kind = PCL_LD_CALL;
        end else if (win_vec[PCL_SLOT_CALL_ACC]) begin
            load_kind = PCL_LD_CALL_ACC;
        end else if (win_vec[PCL_SLOT_BR_ACC]) begin
            load_kind = PCL_LD_BR_ACC;
        end else if (win_vec[PCL_SLOT_BR_IMM]) begin
            load_kind = PCL_LD_BR_IMM;
        end
    end

    pcl_target u_target (
        .load_kind(load_kind),
        .pc_now(pc_now),
        .pc_high_latch(pc_high_latch),
        .acc_value(acc_value),
        .low_write_data(pc_low_write_data),
        .op_field(op_field),
        .pc_target(pc_target)
    );

    assign pc_now = {pc_upper_bits_reg, low_byte_reg};

    // Next counter value; a low-byte write acts even without a fetch
    always_comb begin
        pc_next = pc_now;
        if (pc_low_write) begin
            pc_next = pc_target;
        end else if (fetch_en) begin
            pc_next = pc_target;
        end
    end

    // Upper bits take pc_next: the target on a load, their own value when nothing loads
    always_comb begin
        pc_upper_bits_next = pc_next[PCL_ADDR_W-1:PCL_LOW_W];
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pc_upper_bits_reg <= PCL_RESET_VALUE[PCL_ADDR_W-1:PCL_LOW_W];
        end else begin
            pc_upper_bits_reg <= pc_upper_bits_next;
        end
    end

    // Low byte moves in the same cycle as the upper bits
    always_comb begin
        low_byte_next = pc_next[PCL_LOW_W-1:0];
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            low_byte_reg <= PCL_RESET_VALUE[PCL_LOW_W-1:0];
        end else begin
            low_byte_reg <= low_byte_next;
        end
    end

    // Fault causes are kept apart to ease debug
    always_comb begin
        multi_err_next = multi_err_reg;
        orphan_err_next = orphan_err_reg;
        if (load_taken && multi_load) begin
            multi_err_next = 1'b1;
        end
        if (orphan_jump) begin
            orphan_err_next = 1'b1;
        end
        err_next = multi_err_next | orphan_err_next;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            multi_err_reg <= 1'b0;
            orphan_err_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            multi_err_reg <= multi_err_next;
            orphan_err_reg <= orphan_err_next;
            err_reg <= err_next;
        end
    end

    assign pc_addr = pc_now;
    assign pc_low_byte_reg = low_byte_reg;
    assign load_error = err_reg;
endmodule
`default_nettype wire

// File: src/pcl_pkg.sv
// Purpose: Shared constants and types for the program counter loader.
// Assumes: 15-bit instruction address, 8-bit data path.
// Notes: Load kinds are one-hot so decode faults are visible.
package pcl_pkg;
    localparam int PCL_ADDR_W = 15;
    localparam int PCL_LOW_W = 8;
    localparam int PCL_HIGH_W = 7;
    localparam int PCL_CALL_OP_W = 11;
    localparam int PCL_BRA_OP_W = 9;
    localparam int PCL_CALL_HI_W = 3;
    localparam logic [14:0] PCL_RESET_VALUE = 15'h0000;
    localparam logic [14:0] PCL_ONE = 15'h0001;

    typedef logic [14:0] pcl_addr_t;

    // One-hot load selection, one code per way the counter can change
    typedef enum logic [5:0] {
        PCL_LD_INC = 6'h01,
        PCL_LD_LOW_WRITE = 6'h02,
        PCL_LD_CALL = 6'h04,
        PCL_LD_CALL_ACC = 6'h08,
        PCL_LD_BR_ACC = 6'h10,
        PCL_LD_BR_IMM = 6'h20
    } pcl_load_e;
endpackage

// File: src/pcl_target.sv
// Purpose: Computes the next counter value for each load kind.
// Assumes: Operand fields are right aligned in op_field.
// Notes: Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module pcl_target (
    input wire pcl_pkg::pcl_load_e load_kind,
    input wire pcl_pkg::pcl_addr_t pc_now,
    input wire logic [6:0] pc_high_latch,
    input wire logic [7:0] acc_value,
    input wire logic [7:0] low_write_data,
    input wire logic [10:0] op_field,
    output pcl_pkg::pcl_addr_t pc_target
);
    import pcl_pkg::*;
    pcl_addr_t pc_inc;
    pcl_addr_t bra_offset;

    // Wraps modulo 15 bits
    assign pc_inc = pcl_addr_t'(pc_now + PCL_ONE);
    // Sign extend the 9-bit immediate
    assign bra_offset = {{(PCL_ADDR_W - PCL_BRA_OP_W){op_field[8]}}, op_field[8:0]};

    always_comb begin
        pc_target = pc_inc;
        unique case (load_kind)
            PCL_LD_INC: begin
                pc_target = pc_inc;
            end
            PCL_LD_LOW_WRITE: begin
                pc_target = {pc_high_latch, low_write_data};
            end
            PCL_LD_CALL: begin
                pc_target = {pc_high_latch[6:3], op_field};
            end
            PCL_LD_CALL_ACC: begin
                pc_target = {pc_high_latch, acc_value};
            end
            PCL_LD_BR_ACC: begin
                pc_target = pcl_addr_t'(pc_inc + {7'h00, acc_value});
            end
            PCL_LD_BR_IMM: begin
                pc_target = pcl_addr_t'(pc_inc + bra_offset);
            end
            default: begin
                pc_target = pc_inc;
            end
        endcase
    end
endmodule
`default_nettype wire

// File: testbench/pcl_loader_properties.sv
// Purpose: Port checks of pcl_loader
// Assumes: Sync reset, one strobe per fetch
// Notes: Bound after the module
`timescale 1ns/1ps
`default_nettype none
module pcl_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic fetch_en,
    input wire logic pc_low_write,
    input wire logic [7:0] pc_low_write_data,
    input wire logic call_direct,
    input wire logic call_via_accumulator,
    input wire logic branch_rel_accumulator,
    input wire logic branch_rel_immediate,
    input wire logic [10:0] op_field,
    input wire logic [7:0] acc_value,
    input wire logic [6:0] pc_high_latch,
    input wire logic [14:0] pc_addr
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic f;
    logic [3:0] j;
    logic [14:0] lw, ca, cg, ba, bi;
    assign f = fetch_en && !pc_low_write;
    assign j = {call_direct, call_via_accumulator, branch_rel_accumulator, branch_rel_immediate};
    assign lw = {pc_high_latch, pc_low_write_data};
    assign ca = {pc_high_latch, acc_value};
    assign cg = {pc_high_latch[6:3], op_field};
    assign ba = pc_addr + 15'h1 + {7'h0, acc_value};
    assign bi = pc_addr + 15'h1 + {{6{op_field[8]}}, op_field[8:0]};
    reset_clear_a: assert property (disable iff (1'b0) rst |=> pc_addr == 15'h0)
        else $error("pc not cleared");
    low_write_a: assert property (pc_low_write |=> pc_addr == $past(lw))
        else $error("low write target");
    call_dir_a: assert property (f && j == 4'h8 |=> pc_addr == $past(cg))
        else $error("call target");
    call_acc_a: assert property (f && j == 4'h4 |=> pc_addr == $past(ca))
        else $error("acc call target");
    br_acc_a: assert property (f && j == 4'h2 |=> pc_addr == $past(ba))
        else $error("acc branch target");
    br_imm_a: assert property (f && j == 4'h1 |=> pc_addr == $past(bi))
        else $error("imm branch target");
    inc_step_a: assert property (f && j == 4'h0 |=> pc_addr == $past(pc_addr) + 15'h1)
        else $error("increment");
    hold_pc_a: assert property (!fetch_en && !pc_low_write |=> $stable(pc_addr))
        else $error("pc moved without a load");
endmodule
bind pcl_loader pcl_chk i_pcl_chk (
    .sys_clk(sys_clk),
    .rst(rst),
    .fetch_en(fetch_en),
    .pc_low_write(pc_low_write),
    .pc_low_write_data(pc_low_write_data),
    .call_direct(call_direct),
    .call_via_accumulator(call_via_accumulator),
    .branch_rel_accumulator(branch_rel_accumulator),
    .branch_rel_immediate(branch_rel_immediate),
    .op_field(op_field),
    .acc_value(acc_value),
    .pc_high_latch(pc_high_latch),
    .pc_addr(pc_addr)
);
`default_nettype wire

// File: testbench/pcl_decoder_model.sv
// Purpose: Decoder model raising load strobes
// Assumes: kind is one-hot
// Notes: stall drops fetch_en while jump strobes stay up
`timescale 1ns/1ps
`default_nettype none
module pcl_decoder_model (
    input wire pcl_pkg::pcl_load_e kind,
    input wire logic stall,
    output logic fetch_en,
    output logic pc_low_write,
    output logic call_direct,
    output logic call_via_accumulator,
    output logic branch_rel_accumulator,
    output logic branch_rel_immediate
);
    import pcl_pkg::*;
    assign fetch_en = !stall;
    // Strobe bits follow the one-hot load code, kind bits 5:1, whether or not fetch_en is up
    assign {branch_rel_immediate, branch_rel_accumulator, call_via_accumulator, call_direct,
        pc_low_write} = kind[5:1];
endmodule
`default_nettype wire

// File: testbench/program_counter_loader_tb.sv
// Purpose: Self-checking bench of pcl_loader
// Assumes: 20 MHz clock
// Notes: Random traffic is judged by the bound checker
`timescale 1ns/1ps
`default_nettype none
module program_counter_loader_tb;
    import pcl_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1, stall = 1'b1;
    pcl_load_e kind = PCL_LD_INC;
    logic [7:0] pc_low_write_data = 8'h00, acc_value = 8'h00, pc_low_byte_reg;
    logic [10:0] op_field = 11'h000;
    logic [6:0] pc_high_latch = 7'h00;
    logic fetch_en, pc_low_write, call_direct, call_via_accumulator;
    logic branch_rel_accumulator, branch_rel_immediate, load_error;
    pcl_addr_t pc_addr;
    int n_fail = 0, n_checks = 0;
    pcl_addr_t exp_pc;
    pcl_load_e rk;
    logic rs;
    logic [7:0] rd;
    logic [10:0] ro;
    logic [6:0] rh;
    pcl_decoder_model i_pcl_decoder_model (
        .kind(kind),
        .stall(stall),
        .fetch_en(fetch_en),
        .pc_low_write(pc_low_write),
        .call_direct(call_direct),
        .call_via_accumulator(call_via_accumulator),
        .branch_rel_accumulator(branch_rel_accumulator),
        .branch_rel_immediate(branch_rel_immediate)
    );
    pcl_loader i_pcl_loader (
        .sys_clk(sys_clk),
        .rst(rst),
        .fetch_en(fetch_en),
        .pc_low_write(pc_low_write),
        .pc_low_write_data(pc_low_write_data),
        .call_direct(call_direct),
        .call_via_accumulator(call_via_accumulator),
        .branch_rel_accumulator(branch_rel_accumulator),
        .branch_rel_immediate(branch_rel_immediate),
        .op_field(op_field),
        .acc_value(acc_value),
        .pc_high_latch(pc_high_latch),
        .pc_addr(pc_addr),
        .pc_low_byte_reg(pc_low_byte_reg),
        .load_error(load_error)
    );
    function automatic pcl_addr_t rel(pcl_addr_t p, pcl_addr_t off);
        return p + PCL_ONE + off;
    endfunction
    // Expected counter after one single-strobe load; data feeds both write and accumulator
    function automatic pcl_addr_t model_pc(pcl_addr_t cur, pcl_load_e k, logic s,
            logic [7:0] d, logic [10:0] o, logic [6:0] h);
        pcl_addr_t r;
        r = cur;
        if (k == PCL_LD_LOW_WRITE) begin
            r = {h, d};
        end else if (!s) begin
            if (k == PCL_LD_INC) begin
                r = cur + PCL_ONE;
            end else if (k == PCL_LD_CALL) begin
                r = {h[6:3], o};
            end else if (k == PCL_LD_CALL_ACC) begin
                r = {h, d};
            end else if (k == PCL_LD_BR_ACC) begin
                r = rel(cur, {7'h00, d});
            end else begin
                r = rel(cur, {{6{o[8]}}, o[8:0]});
            end
        end
        return r;
    endfunction
    task check_err(logic e);
        n_checks++;
        if (load_error !== e) begin
            n_fail++;
            $display("CHECK FAILED load_error exp %b got %b", e, load_error);
        end
    endtask
    task drv(pcl_load_e k, logic s, logic [7:0] d, logic [10:0] o, logic [6:0] h);
        kind <= k;
        stall <= s;
        pc_low_write_data <= d;
        acc_value <= d;
        op_field <= o;
        pc_high_latch <= h;
    endtask
    // One load, then idle inputs, then compare at the next falling edge
    task step(pcl_load_e k, logic s, logic [7:0] d, logic [10:0] o, logic [6:0] h, pcl_addr_t e);
        @(posedge sys_clk);
        drv(k, s, d, o, h);
        @(posedge sys_clk);
        drv(PCL_LD_INC, 1'b1, d, o, h);
        @(negedge sys_clk);
        n_checks++;
        if (pc_addr !== e || pc_low_byte_reg !== e[7:0]) begin
            n_fail++;
            $display("CHECK FAILED pc_addr exp %h got %h", e, pc_addr);
        end
    endtask
    task stop_test;
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial forever #25 sys_clk = ~sys_clk;
    initial begin
        #400000;
        n_fail++;
        stop_test;
    end
    initial begin
        void'($urandom(65));
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        step(PCL_LD_LOW_WRITE, 1'b1, 8'hff, 11'h000, 7'h7f, 15'h7fff);
        step(PCL_LD_INC, 1'b0, 8'h00, 11'h000, 7'h00, 15'h0000);
        step(PCL_LD_BR_IMM, 1'b0, 8'h00, 11'h1ff, 7'h00, rel(15'h0000, 15'h7fff));
        step(PCL_LD_BR_ACC, 1'b0, 8'hff, 11'h000, 7'h00, rel(15'h0000, 15'h00ff));
        step(PCL_LD_CALL, 1'b0, 8'h00, 11'h7ff, 7'h55, 15'h57ff);
        step(PCL_LD_CALL_ACC, 1'b0, 8'ha5, 11'h000, 7'h2a, 15'h2aa5);
        check_err(1'b0);
        step(PCL_LD_CALL, 1'b1, 8'h00, 11'h123, 7'h11, 15'h2aa5);
        check_err(1'b1);
        @(posedge sys_clk);
        rst <= 1'b1;
        step(PCL_LD_INC, 1'b0, 8'h00, 11'h000, 7'h00, 15'h0000);
        @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        check_err(1'b0);
        $display("directed test done");
        exp_pc = 15'h0000;
        repeat (1000) begin
            rk = pcl_load_e'(6'h01 << ($urandom % 6));
            rs = 1'($urandom);
            rd = 8'($urandom);
            ro = 11'($urandom);
            rh = 7'($urandom);
            exp_pc = model_pc(exp_pc, rk, rs, rd, ro, rh);
            step(rk, rs, rd, ro, rh, exp_pc);
        end
        $display("model test done");
        repeat (2000) begin
            @(posedge sys_clk);
            drv(pcl_load_e'(6'h01 << ($urandom % 6)), 1'($urandom), 8'($urandom), 11'($urandom),
                7'($urandom));
        end
        $display("random test done");
        stop_test;
    end
endmodule
`default_nettype wire
